// *** uvdt_pkg.sv ***
/*
 package for the definite-time undervoltage trip block: setting ranges, defaults, widths,
 operation selector codes and timing constants.
 assumes a 25 MHz system clock and magnitudes scaled so that nominal equals UVDT_NOM_MAG.
*/
package uvdt_pkg;
	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int unsigned UVDT_MAG_W   = 16;
	localparam int unsigned UVDT_PCT_W   = 8;
	localparam int unsigned UVDT_MS_W    = 16;
	localparam int unsigned UVDT_TICK_W  = 15;
	localparam int unsigned UVDT_PROD_W  = UVDT_MAG_W + 2 * UVDT_PCT_W;
	localparam int unsigned UVDT_NPH     = 3;

	// magnitude that stands for 100 percent of nominal
	localparam logic [UVDT_MAG_W-1:0] UVDT_NOM_MAG = 16'h2710;
	localparam logic [UVDT_PCT_W-1:0] UVDT_HUNDRED = 8'h64;

	// ----------------------------------------------------------------
	// setting ranges and defaults
	// ----------------------------------------------------------------
	localparam logic [UVDT_PCT_W-1:0] UVDT_START_MIN = 8'h1e; // 30 %
	localparam logic [UVDT_PCT_W-1:0] UVDT_START_MAX = 8'h82; // 130 %
	localparam logic [UVDT_PCT_W-1:0] UVDT_START_DEF = 8'h5a; // 90 %
	localparam logic [UVDT_PCT_W-1:0] UVDT_BLOCK_MIN = 8'h00; // 0 %
	localparam logic [UVDT_PCT_W-1:0] UVDT_BLOCK_MAX = 8'h14; // 20 %
	localparam logic [UVDT_PCT_W-1:0] UVDT_BLOCK_DEF = 8'h0a; // 10 %
	localparam logic [UVDT_PCT_W-1:0] UVDT_HYST_MIN  = 8'h01; // 1 %
	localparam logic [UVDT_PCT_W-1:0] UVDT_HYST_MAX  = 8'h0a; // 10 %
	localparam logic [UVDT_PCT_W-1:0] UVDT_HYST_DEF  = 8'h05; // 5 %
	localparam logic [UVDT_MS_W-1:0]  UVDT_DELAY_MIN = 16'h0032; // 50 ms
	localparam logic [UVDT_MS_W-1:0]  UVDT_DELAY_MAX = 16'hea60; // 60000 ms
	localparam logic [UVDT_MS_W-1:0]  UVDT_DELAY_DEF = 16'h0064; // 100 ms
	localparam logic                  UVDT_STONLY_DEF = 1'b0;

	// ----------------------------------------------------------------
	// timing: one millisecond tick from the system clock
	// ----------------------------------------------------------------
	localparam int unsigned UVDT_CLK_HZ   = 25000000;
	localparam int unsigned UVDT_TICK_MS  = 1;
	localparam int unsigned UVDT_TICK_CYC = UVDT_CLK_HZ / 1000 * UVDT_TICK_MS;

	// operation selector
	typedef enum logic [1:0] {
		UVDT_OP_OFF,
		UVDT_OP_ONE,
		UVDT_OP_TWO,
		UVDT_OP_ALL
	} uvdt_op_e;

	typedef logic [UVDT_NPH-1:0] uvdt_ph_t;
endpackage

// *** uvdt_phase_if.sv ***
/*
 interface carrying the per-phase results from the characteristic stage to the
 decision logic. assumes both ends share i_clk_sys.
*/
`timescale 1ns/1ns
interface uvdt_phase_if;
	import uvdt_pkg::*;
	uvdt_ph_t start;
	uvdt_ph_t trip;
	modport charc (output start, output trip);
	modport decide (input start, input trip);
endinterface

// *** uvdt_phase_chan.sv ***
/*
 one phase of the characteristic stage: start decision with hysteresis and the
 definite-time counter. assumes thresholds precomputed in magnitude units and a 1 ms tick.
*/
`timescale 1ns/1ns
module uvdt_phase_chan
	import uvdt_pkg::*;
(
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_rstn,
	input  wire logic                  i_enable,
	input  wire logic                  i_tick,
	input  wire logic [UVDT_MAG_W-1:0] i_mag,
	input  wire logic [UVDT_PROD_W-1:0] i_start_lvl,
	input  wire logic [UVDT_PROD_W-1:0] i_release_lvl,
	input  wire logic [UVDT_PROD_W-1:0] i_block_lvl,
	input  wire logic [UVDT_MS_W-1:0]  i_delay_ms,
	output logic                       o_start,
	output logic                       o_trip
);
	logic                 start_q, start_d;
	logic                 trip_q, trip_d;
	logic [UVDT_MS_W-1:0] cnt_q, cnt_d;
	logic [UVDT_PROD_W-1:0] mag_w;

	// magnitude scaled by 100*100 so it meets the levels, which carry nom*pct*100
	assign mag_w = UVDT_PROD_W'(i_mag) * UVDT_PROD_W'(UVDT_HUNDRED) * UVDT_PROD_W'(UVDT_HUNDRED);

	// ----------------------------------------------------------------
	// start decision and delay counter
	// ----------------------------------------------------------------
	// pick up below start level, drop out above the raised level or below the block level
	always_comb begin
		start_d = start_q;
		trip_d  = trip_q;
		cnt_d   = cnt_q;
		if (!i_enable || mag_w < i_block_lvl) begin
			start_d = 1'b0;
		end else if (!start_q) begin
			start_d = (mag_w < i_start_lvl);
		end else if (mag_w > i_release_lvl) begin
			start_d = 1'b0;
		end
		if (!start_d) begin
			cnt_d  = '0;
			trip_d = 1'b0;
		end else if (i_tick && !trip_q) begin
			// delay counted in whole ms while the start holds
			if (cnt_q + 16'h0001 >= i_delay_ms) begin
				trip_d = 1'b1;
			end
			cnt_d = cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			start_q <= 1'b0;
			trip_q  <= 1'b0;
			cnt_q   <= '0;
		end else begin
			start_q <= start_d;
			trip_q  <= trip_d;
			cnt_q   <= cnt_d;
		end
	end

	assign o_start = start_q;
	assign o_trip  = trip_q;

	// trip never stands without start
	trip_needs_start_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		trip_q |-> start_q) else $error("phase trip without start");
	// below block level the start is gone next cycle
	block_drops_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(mag_w < i_block_lvl) |=> !start_q) else $error("start under block level");
endmodule

// *** uvdt_trip.sv ***
/*
 definite-time undervoltage trip: three phase channels and the decision logic.
 assumes magnitudes already selected upstream (phase or phase-to-phase) and scaled so
 that UVDT_NOM_MAG is nominal; settings are held stable by the surrounding logic.
*/
`timescale 1ns/1ns

// Notes on behaviour
// - each phase starts while its magnitude is under the start level and over the block level.
// - general start rises when any phase meets the start condition under one-of-three.
// - in medium-voltage use the three inputs are phase-to-phase magnitudes by default.
// - a trip is given only after the full delay of a sustained start, unless start-only is set.
// - operation selector is off, one of three, two of three or all, defaulting to off.
// - start level is 30 to 130 percent in 1 percent steps, default 90.
// - a phase under the block level (0 to 20 percent, default 10) does not start.
// - reset hysteresis is 1 to 10 percent in 1 percent steps, default 5.
// - start-only flag set to zero (the default) lets trips through.
// - trip delay is 50 to 60000 ms in 1 ms steps, default 100.
// - the characteristic stage counts the delay per phase while started, then flags trip.
// - three start and three trip channels exist, one per measured voltage or voltage pair.
// - per-phase trips stay inside; only the general trip leaves the block.
// - the block input forces all starts and trips inactive while high.
// - per-phase trips combine into the general trip, gated by block and start-only.
module uvdt_trip
	import uvdt_pkg::*;
(
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_rstn,
	input  wire logic [UVDT_MAG_W-1:0] i_volt_mag_a,
	input  wire logic [UVDT_MAG_W-1:0] i_volt_mag_b,
	input  wire logic [UVDT_MAG_W-1:0] i_volt_mag_c,
	input  wire logic [1:0]            i_operation_select,
	input  wire logic [UVDT_PCT_W-1:0] i_start_threshold_pct,
	input  wire logic [UVDT_PCT_W-1:0] i_block_threshold_pct,
	input  wire logic [UVDT_PCT_W-1:0] i_reset_hysteresis_pct,
	input  wire logic                  i_start_only_flag,
	input  wire logic [UVDT_MS_W-1:0]  i_trip_delay_ms,
	input  wire logic                  i_function_block_in,
	output logic                       o_start_phase_a,
	output logic                       o_start_phase_b,
	output logic                       o_start_phase_c,
	output logic                       o_general_start_out,
	output logic                       o_general_trip_out
);
	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// clamp a percent setting into its documented range
	function automatic logic [UVDT_PCT_W-1:0] clamp_pct(input logic [UVDT_PCT_W-1:0] v,
		input logic [UVDT_PCT_W-1:0] lo, input logic [UVDT_PCT_W-1:0] hi);
		logic [UVDT_PCT_W-1:0] r;
		r = v;
		if (v < lo) r = lo;
		if (v > hi) r = hi;
		return r;
	endfunction

	// number of set bits among three phases, used for start and trip voting
	function automatic logic [1:0] count3(input uvdt_ph_t p);
		logic [1:0] n;
		n = 2'(p[0]) + 2'(p[1]) + 2'(p[2]);
		return n;
	endfunction

	// vote per operation selector; off never passes
	function automatic logic vote(input uvdt_op_e op, input uvdt_ph_t p);
		logic r;
		case (op)
			UVDT_OP_ONE: r = (count3(p) >= 2'd1);
			UVDT_OP_TWO: r = (count3(p) >= 2'd2);
			UVDT_OP_ALL: r = (count3(p) == 2'd3);
			default:     r = 1'b0;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// settings and derived levels
	// ----------------------------------------------------------------
	uvdt_op_e               op_w;
	logic [UVDT_PCT_W-1:0]  st_pct, bl_pct, hy_pct;
	logic [UVDT_MS_W-1:0]   delay_w;
	logic [UVDT_PROD_W-1:0] start_lvl, block_lvl, release_lvl;
	logic                   enable_w;

	assign op_w   = uvdt_op_e'(i_operation_select);
	assign st_pct = clamp_pct(i_start_threshold_pct, UVDT_START_MIN, UVDT_START_MAX);
	assign bl_pct = clamp_pct(i_block_threshold_pct, UVDT_BLOCK_MIN, UVDT_BLOCK_MAX);
	assign hy_pct = clamp_pct(i_reset_hysteresis_pct, UVDT_HYST_MIN, UVDT_HYST_MAX);

	// delay clamped to its range; shorter settings would undercut the minimum operate time
	always_comb begin
		delay_w = i_trip_delay_ms;
		if (i_trip_delay_ms < UVDT_DELAY_MIN) delay_w = UVDT_DELAY_MIN;
		if (i_trip_delay_ms > UVDT_DELAY_MAX) delay_w = UVDT_DELAY_MAX;
	end

	// levels compared as mag*100*100 against nom*pct*100 to keep hysteresis exact
	assign start_lvl   = UVDT_PROD_W'(UVDT_NOM_MAG) * UVDT_PROD_W'(st_pct)
		* UVDT_PROD_W'(UVDT_HUNDRED);
	assign block_lvl   = UVDT_PROD_W'(UVDT_NOM_MAG) * UVDT_PROD_W'(bl_pct)
		* UVDT_PROD_W'(UVDT_HUNDRED);
	assign release_lvl = UVDT_PROD_W'(UVDT_NOM_MAG) * UVDT_PROD_W'(st_pct)
		* (UVDT_PROD_W'(UVDT_HUNDRED) + UVDT_PROD_W'(hy_pct));

	// function runs only when selected and not blocked
	assign enable_w = (op_w != UVDT_OP_OFF) && !i_function_block_in;

	// ----------------------------------------------------------------
	// millisecond tick
	// ----------------------------------------------------------------
	logic [UVDT_TICK_W-1:0] tick_cnt_q, tick_cnt_d;
	logic                   tick_q, tick_d;

	always_comb begin
		tick_d     = 1'b0;
		tick_cnt_d = tick_cnt_q + 15'h0001;
		if (tick_cnt_q == UVDT_TICK_W'(UVDT_TICK_CYC - 1)) begin
			tick_cnt_d = '0;
			tick_d     = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			tick_q     <= tick_d;
		end
	end

	// ----------------------------------------------------------------
	// characteristic stage, one channel per measured voltage
	// ----------------------------------------------------------------
	// channel order a, b, c maps to the pairs ab, bc, ca when fed phase-to-phase
	uvdt_phase_if ph_if ();
	logic [UVDT_MAG_W-1:0] mag_arr [UVDT_NPH];

	assign mag_arr[0] = i_volt_mag_a;
	assign mag_arr[1] = i_volt_mag_b;
	assign mag_arr[2] = i_volt_mag_c;

	genvar g;
	generate
		for (g = 0; g < UVDT_NPH; g++) begin : g_ph
			uvdt_phase_chan u_chan (
				.i_clk_sys     (i_clk_sys),
				.i_rstn        (i_rstn),
				.i_enable      (enable_w),
				.i_tick        (tick_q),
				.i_mag         (mag_arr[g]),
				.i_start_lvl   (start_lvl),
				.i_release_lvl (release_lvl),
				.i_block_lvl   (block_lvl),
				.i_delay_ms    (delay_w),
				.o_start       (ph_if.start[g]),
				.o_trip        (ph_if.trip[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// decision logic
	// ----------------------------------------------------------------
	logic gen_start_q, gen_start_d;
	logic gen_trip_q, gen_trip_d;
	uvdt_ph_t ph_start_q, ph_start_d;

	// block acts at once on the outputs so no stale start leaks for a cycle
	always_comb begin
		ph_start_d  = enable_w ? ph_if.start : '0;
		gen_start_d = enable_w && vote(op_w, ph_if.start);
		gen_trip_d  = enable_w && !i_start_only_flag
			&& vote(op_w, ph_if.trip);
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ph_start_q  <= '0;
			gen_start_q <= 1'b0;
			gen_trip_q  <= 1'b0;
		end else begin
			ph_start_q  <= ph_start_d;
			gen_start_q <= gen_start_d;
			gen_trip_q  <= gen_trip_d;
		end
	end

	// per-phase trips are not brought out
	assign o_start_phase_a     = ph_start_q[0];
	assign o_start_phase_b     = ph_start_q[1];
	assign o_start_phase_c     = ph_start_q[2];
	assign o_general_start_out = gen_start_q;
	assign o_general_trip_out  = gen_trip_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_blocked;
		i_function_block_in ##1 i_function_block_in;
	endsequence

	block_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		s_blocked |-> !o_general_start_out && !o_general_trip_out) else $error("out while blocked");
	stonly_notrip_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		$past(i_start_only_flag) |-> !o_general_trip_out) else $error("trip in start-only");
	off_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		($past(i_operation_select) == 2'b00) |-> !o_general_start_out) else $error("start when off");
	any_start_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(enable_w && op_w == UVDT_OP_ONE && |ph_if.start) |=> o_general_start_out)
		else $error("general start missed");
	all_vote_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(op_w == UVDT_OP_ALL && !(&ph_if.start)) |=> !o_general_start_out)
		else $error("all-phase vote broken");
	trip_has_start_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		o_general_trip_out |-> $past(|ph_if.start)) else $error("trip without start");
	tick_period_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		tick_q |=> !tick_q) else $error("tick wider than one cycle");
	phase_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		$past(!enable_w) |-> (ph_start_q == '0)) else $error("phase start while disabled");
endmodule

// *** uvdt_src_model.sv ***
/*
 model of the upstream phasor stage: presents the three magnitudes one clock after they are
 requested, as a registered calculation would. assumes the bench requests on rising edges.
*/
`timescale 1ns/1ns
module uvdt_src_model
	import uvdt_pkg::*;
(
	input  wire logic                  i_clk_sys,
	input  wire logic [UVDT_MAG_W-1:0] i_req_a,
	input  wire logic [UVDT_MAG_W-1:0] i_req_b,
	input  wire logic [UVDT_MAG_W-1:0] i_req_c,
	output logic      [UVDT_MAG_W-1:0] o_mag_a,
	output logic      [UVDT_MAG_W-1:0] o_mag_b,
	output logic      [UVDT_MAG_W-1:0] o_mag_c
);
	// one stage of latency, like a block-based calculation
	always_ff @(posedge i_clk_sys) begin
		o_mag_a <= i_req_a;
		o_mag_b <= i_req_b;
		o_mag_c <= i_req_c;
	end
endmodule

// *** tb_top.sv ***
/*
 self-checking bench for the undervoltage trip block with an integer reference model.
 assumes the trip delay (50 ms minimum) is far longer than the run, so trips stay low.
*/
`timescale 1ns/1ns
module tb_top
	import uvdt_pkg::*;
;
	logic        clk, rstn, so, blk;
	logic [15:0] req_a, req_b, req_c, mag_a, mag_b, mag_c, dly;
	logic [1:0]  op;
	logic [7:0]  st, bl, hy;
	logic        s_a, s_b, s_c, g_st, g_tr;
	int          errors, tests_run, seed, m[3], k;

	uvdt_src_model uvdt_src_model_inst (.i_clk_sys(clk), .i_req_a(req_a), .i_req_b(req_b),
		.i_req_c(req_c), .o_mag_a(mag_a), .o_mag_b(mag_b), .o_mag_c(mag_c));
	uvdt_trip uvdt_trip_inst (.i_clk_sys(clk), .i_rstn(rstn), .i_volt_mag_a(mag_a),
		.i_volt_mag_b(mag_b), .i_volt_mag_c(mag_c), .i_operation_select(op),
		.i_start_threshold_pct(st), .i_block_threshold_pct(bl),
		.i_reset_hysteresis_pct(hy), .i_start_only_flag(so), .i_trip_delay_ms(dly),
		.i_function_block_in(blk), .o_start_phase_a(s_a), .o_start_phase_b(s_b),
		.o_start_phase_c(s_c), .o_general_start_out(g_st), .o_general_trip_out(g_tr));

	// ----------------------------------------------------------------
	// checking and verdict
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// reference start state of one phase, holding inside the hysteresis band
	function automatic int nxt(int cur, int v);
		if (op == 2'h0 || blk) return 0;
		if (v < 100 * int'(bl)) return 0;
		if (v < 100 * int'(st)) return 1;
		if (v > int'(st) * (100 + int'(hy))) return 0;
		return cur;
	endfunction

	// drive magnitudes, let them settle, then compare every output with the model
	task automatic apply(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
		int n;
		@(posedge clk);
		req_a <= a;
		req_b <= b;
		req_c <= c;
		repeat (5) @(posedge clk);
		@(negedge clk);
		m[0] = nxt(m[0], a);
		m[1] = nxt(m[1], b);
		m[2] = nxt(m[2], c);
		n = m[0] + m[1] + m[2];
		check(16'(s_a), 16'(m[0]));
		check(16'(s_b), 16'(m[1]));
		check(16'(s_c), 16'(m[2]));
		check(16'(g_st), 16'(op != 2'h0 && n >= int'(op)));
		check(16'(g_tr), 16'h0000);
	endtask

	task automatic setup(input logic [1:0] o, input logic [7:0] s, input logic [7:0] b,
		input logic [7:0] h, input logic f, input logic x);
		@(posedge clk);
		op <= o;
		st <= s;
		bl <= b;
		hy <= h;
		so <= f;
		blk <= x;
		apply(16'hffff, 16'hffff, 16'hffff);
	endtask

	// ----------------------------------------------------------------
	// clock, reset and watchdog
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// the whole sequence needs about 31000 cycles; the limit leaves ample margin
	initial begin
		#(40 * 80000);
		errors++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 78;
		rstn = 1'b0;
		{req_a, req_b, req_c} = {3{16'hffff}};
		op = 2'h0;
		st = 8'h5a;
		bl = 8'h0a;
		hy = 8'h05;
		so = 1'b0;
		dly = 16'h0032;
		blk = 1'b0;
		m = '{0, 0, 0};
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		check(16'({s_a, s_b, s_c, g_st, g_tr}), 16'h0000);
		$display("test reset done");
		// band edges: block level, start level, release level at 90 % and 5 %
		setup(2'h1, 8'h5a, 8'h0a, 8'h05, 1'b0, 1'b0);
		apply(16'h03e7, 16'hffff, 16'hffff);
		apply(16'h03e8, 16'hffff, 16'hffff);
		apply(16'h2327, 16'hffff, 16'hffff);
		apply(16'h24ea, 16'hffff, 16'hffff);
		apply(16'h24eb, 16'hffff, 16'hffff);
		apply(16'h2328, 16'h1f40, 16'hffff);
		$display("test hysteresis done");
		// every selector code against every set of low phases
		for (k = 0; k < 32; k++) begin
			setup(k[4:3], 8'h5a, 8'h0a, 8'h05, 1'b0, 1'b0);
			apply(k[0] ? 16'h1388 : 16'hffff, k[1] ? 16'h1388 : 16'hffff,
				k[2] ? 16'h1388 : 16'hffff);
		end
		$display("test voting done");
		// sustained start shorter than the minimum delay must not trip
		setup(2'h1, 8'h5a, 8'h0a, 8'h05, 1'b0, 1'b0);
		apply(16'h1388, 16'h1388, 16'h1388);
		repeat (30000) @(posedge clk);
		apply(16'h1388, 16'h1388, 16'h1388);
		@(posedge clk);
		blk <= 1'b1;
		apply(16'h1388, 16'h1388, 16'h1388);
		$display("test delay and block done");
		// random settings within range and random magnitudes
		for (k = 0; k < 40; k++) begin
			setup(2'($random(seed)), 8'h1e + 8'($unsigned($random(seed)) % 101),
				8'($unsigned($random(seed)) % 21), 8'h01 + 8'($unsigned($random(seed)) % 10),
				1'($random(seed)), ($random(seed) % 8) == 0);
			apply(16'($unsigned($random(seed)) % 14000), 16'($unsigned($random(seed)) % 14000),
				16'($unsigned($random(seed)) % 14000));
		end
		$display("test random done");
		give_verdict();
	end
endmodule
